// File: hdl/adcr_regs.sv
// How it works
// - Channel 4 phase field bits 7:2 delays channel 4 by N modulator cycles.
// - Channel 4 phase register at 0x61 resets to zero, so no delay.
// - One-hot trim bits 7:4 pick input common-mode pull resistor, zero none.
// - Global bit 3 enables quantizer offset calibration; reset clear.
// - Global bit 2 inverts output samples; clear passes them unchanged.
// - DSP bits 7:6 pick decimation response; code 3 reserved.
// - DSP bits 5:4 codes 1 to 3 select fixed high-pass cutoffs.
// - High-pass code 0 routes through first-order IIR, default all-pass.
// - DSP bits 3:2 set cascaded biquad count, reset two.
// - DSP bit 1 clear soft-steps volume changes; set jumps at once.
// - DSP bit 0 set makes active channels use channel 1 volume.
// - Ganged volume holds even when channel 1 is disabled.
// - DSP register at 0x72 resets to 0x18.
// - Channel enable register at 0x76 resets to 0xCC.
// - Channel enable bits 7 to 4 enable channels 1 to 4.
// - Volume code 0 mutes, 161 is unity, half dB per step.
`timescale 1ns/10ps

module adcr_regs
    import adcr_pkg::*;
(
    // Clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    // Register access port
    input  wire logic                              reg_wr_en,
    input  wire logic                              reg_rd_en,
    input  wire logic [7:0]                        reg_addr,
    input  wire logic [7:0]                        reg_wr_data,
    output logic      [7:0]                        reg_rd_data,
    output logic                                   reg_rd_valid,
    // Modulator bitstreams
    input  wire logic                              mod_clk_en,
    input  wire logic [ADCR_NUM_CH-1:0]            mod_bits_in,
    output logic      [ADCR_NUM_CH-1:0]            mod_bits_out,
    // Sample path
    input  wire logic                              sample_in_valid,
    input  wire logic [ADCR_NUM_CH-1:0][ADCR_SAMPLE_W-1:0] sample_in,
    output logic                                   sample_out_valid,
    output logic      [ADCR_NUM_CH-1:0][ADCR_SAMPLE_W-1:0] sample_out,
    // Volume settings held elsewhere
    input  wire logic [ADCR_NUM_CH-1:0][7:0]       per_channel_volume,
    output logic      [ADCR_NUM_CH-1:0][7:0]       digital_volume,
    output logic      [ADCR_NUM_CH-1:0]            channel_mute,
    output logic      [ADCR_NUM_CH-1:0]            volume_ramping,
    // Analog and filter configuration
    output logic      [3:0]                        input_common_mode_trim,
    output logic                                   quantizer_offset_cal_enable,
    output logic      [1:0]                        decimation_response_select,
    output logic                                   decimation_reserved,
    output logic      [1:0]                        highpass_select,
    output logic                                   highpass_iir_route,
    output logic      [1:0]                        biquad_count,
    output logic      [ADCR_NUM_BQ-1:0]            biquad_stage_enable,
    output logic                                   soft_step_enable,
    output logic                                   volume_gang_enable,
    output logic      [ADCR_NUM_CH-1:0]            input_channel_enable
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0]                              ch4_phase_delay;
        logic [3:0]                              cm_trim;
        logic                                    qcal_en;
        logic                                    data_invert;
        logic [7:0]                              dsp_cfg;
        logic [3:0]                              chan_en;
        logic [ADCR_NUM_BQ-1:0]                  bq_en;
        logic [7:0]                              rd_data;
        logic                                    rd_valid;
        logic [ADCR_DELAY_MAX-1:0]               ch4_line;
        logic [ADCR_NUM_CH-1:0]                  mod_out;
        logic [ADCR_NUM_CH-1:0][ADCR_SAMPLE_W-1:0] smp_out;
        logic                                    smp_valid;
    } adcr_regs_state_t;

    adcr_regs_state_t state;
    adcr_regs_state_t next_state;

    logic [ADCR_NUM_CH-1:0][7:0] vol_target;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Register readback with reserved bits forced to their constants
    function automatic logic [7:0] read_reg(input adcr_regs_state_t s,
                                            input logic [7:0]       addr);
        logic [7:0] val;
        val = ADCR_UNMAPPED_VAL;
        unique case (addr)
            ADCR_ADDR_CH4_PHASE_CAL: val = {s.ch4_phase_delay,
                                            ADCR_RSVD_CAL_VAL};
            ADCR_ADDR_GLOBAL_CFG:    val = {s.cm_trim, s.qcal_en,
                                            s.data_invert,
                                            ADCR_RSVD_GCFG_VAL};
            ADCR_ADDR_DSP_CFG:       val = s.dsp_cfg;
            ADCR_ADDR_CHAN_EN:       val = {s.chan_en, ADCR_RSVD_CHEN_VAL};
            default:                 val = ADCR_UNMAPPED_VAL;
        endcase
        return val;
    endfunction

    // Biquad count to per-stage enables
    function automatic logic [ADCR_NUM_BQ-1:0] bq_decode(
        input logic [1:0] count);
        logic [ADCR_NUM_BQ-1:0] en;
        en = '0;
        for (int k = 0; k < ADCR_NUM_BQ; k++) begin
            en[k] = (int'(count) > k);
        end
        return en;
    endfunction

    // Invert a sample, saturating the most negative code
    function automatic logic [ADCR_SAMPLE_W-1:0] invert_sample(
        input logic [ADCR_SAMPLE_W-1:0] x);
        logic [ADCR_SAMPLE_W-1:0] neg_min;
        neg_min = {1'b1, {(ADCR_SAMPLE_W-1){1'b0}}};
        if (x == neg_min) begin
            return ~neg_min;
        end
        return ADCR_SAMPLE_W'(-x);
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;

        // Register writes; reserved positions not stored
        if (reg_wr_en) begin
            unique case (reg_addr)
                ADCR_ADDR_CH4_PHASE_CAL: begin
                    next_state.ch4_phase_delay =
                        reg_wr_data[ADCR_PCAL_MSB:ADCR_PCAL_LSB];
                end
                ADCR_ADDR_GLOBAL_CFG: begin
                    next_state.cm_trim =
                        reg_wr_data[ADCR_TRIM_MSB:ADCR_TRIM_LSB];
                    next_state.qcal_en     = reg_wr_data[ADCR_QCAL_BIT];
                    next_state.data_invert = reg_wr_data[ADCR_INVERT_BIT];
                end
                ADCR_ADDR_DSP_CFG: begin
                    next_state.dsp_cfg = reg_wr_data;
                end
                ADCR_ADDR_CHAN_EN: begin
                    next_state.chan_en =
                        reg_wr_data[ADCR_CHEN_MSB:ADCR_CHEN_LSB];
                end
                default: begin
                    next_state.rd_valid = state.rd_valid;
                end
            endcase
        end

        next_state.bq_en = bq_decode(
            next_state.dsp_cfg[ADCR_BQ_MSB:ADCR_BQ_LSB]);

        next_state.rd_valid = reg_rd_en;
        if (reg_rd_en) begin
            next_state.rd_data = read_reg(state, reg_addr);
        end

        // channel 4 delay line on modulator enable
        if (mod_clk_en) begin
            next_state.ch4_line = {state.ch4_line[ADCR_DELAY_MAX-2:0],
                                   mod_bits_in[ADCR_NUM_CH-1]};
            next_state.mod_out = mod_bits_in;
            if (state.ch4_phase_delay != '0) begin
                next_state.mod_out[ADCR_NUM_CH-1] =
                    state.ch4_line[state.ch4_phase_delay - 6'h01];
            end
        end

        next_state.smp_valid = sample_in_valid;
        if (sample_in_valid) begin
            for (int c = 0; c < ADCR_NUM_CH; c++) begin
                if (!state.chan_en[ADCR_NUM_CH-1-c]) begin
                    next_state.smp_out[c] = '0;
                end else if (state.data_invert) begin
                    next_state.smp_out[c] = invert_sample(sample_in[c]);
                end else begin
                    next_state.smp_out[c] = sample_in[c];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state.ch4_phase_delay <= ADCR_RST_CH4_PHASE_CAL[ADCR_PCAL_MSB:
                                                            ADCR_PCAL_LSB];
            state.cm_trim         <= ADCR_RST_GLOBAL_CFG[ADCR_TRIM_MSB:
                                                         ADCR_TRIM_LSB];
            state.qcal_en         <= ADCR_RST_GLOBAL_CFG[ADCR_QCAL_BIT];
            state.data_invert     <= ADCR_RST_GLOBAL_CFG[ADCR_INVERT_BIT];
            state.dsp_cfg         <= ADCR_RST_DSP_CFG;
            state.chan_en         <= ADCR_RST_CHAN_EN[ADCR_CHEN_MSB:
                                                      ADCR_CHEN_LSB];
            state.bq_en           <= bq_decode(
                ADCR_RST_DSP_CFG[ADCR_BQ_MSB:ADCR_BQ_LSB]);
            state.rd_data         <= ADCR_UNMAPPED_VAL;
            state.rd_valid        <= 1'b0;
            state.ch4_line        <= '0;
            state.mod_out         <= '0;
            state.smp_out         <= '0;
            state.smp_valid       <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Volume targets and soft-step ramps
    // ------------------------------------------------------------------

    // Gang, enable and mute selection per channel
    always_comb begin
        for (int c = 0; c < ADCR_NUM_CH; c++) begin
            if (!state.chan_en[ADCR_NUM_CH-1-c]) begin
                vol_target[c] = ADCR_VOL_MUTE;
            end else if (state.dsp_cfg[ADCR_GANG_BIT]) begin
                vol_target[c] = per_channel_volume[0];
            end else begin
                vol_target[c] = per_channel_volume[c];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < ADCR_NUM_CH; g++) begin : gen_ramp
            adcr_vol_ramp u_ramp (
                .clk_sys          (clk_sys),
                .rst              (rst),
                .step_en          (sample_in_valid),
                .soft_step_enable (soft_step_enable),
                .target_volume    (vol_target[g]),
                .applied_volume   (digital_volume[g]),
                .ramp_busy        (volume_ramping[g])
            );
            assign channel_mute[g] = (digital_volume[g] == ADCR_VOL_MUTE);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Register port answers
    assign reg_rd_data  = state.rd_data;
    assign reg_rd_valid = state.rd_valid;

    // Data path results
    assign mod_bits_out     = state.mod_out;
    assign sample_out       = state.smp_out;
    assign sample_out_valid = state.smp_valid;

    assign input_common_mode_trim      = state.cm_trim;
    assign quantizer_offset_cal_enable = state.qcal_en;
    assign decimation_response_select  =
        state.dsp_cfg[ADCR_DECI_MSB:ADCR_DECI_LSB];
    assign decimation_reserved         =
        (state.dsp_cfg[ADCR_DECI_MSB:ADCR_DECI_LSB] == ADCR_DECI_RESERVED);
    assign highpass_select             =
        state.dsp_cfg[ADCR_HPF_MSB:ADCR_HPF_LSB];
    assign highpass_iir_route          =
        (state.dsp_cfg[ADCR_HPF_MSB:ADCR_HPF_LSB] == ADCR_HPF_IIR);
    assign biquad_count                =
        state.dsp_cfg[ADCR_BQ_MSB:ADCR_BQ_LSB];
    assign biquad_stage_enable         = state.bq_en;
    assign soft_step_enable            = ~state.dsp_cfg[ADCR_SOFT_DIS];
    assign volume_gang_enable          = state.dsp_cfg[ADCR_GANG_BIT];
    // channel order 1 at bit 0
    assign input_channel_enable        = {<<{state.chan_en}};

endmodule

// File: hdl/adcr_pkg.sv
package adcr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADCR_ADDR_CH4_PHASE_CAL = 8'h61;
    localparam logic [7:0] ADCR_ADDR_GLOBAL_CFG    = 8'h62;
    localparam logic [7:0] ADCR_ADDR_DSP_CFG       = 8'h72;
    localparam logic [7:0] ADCR_ADDR_CHAN_EN       = 8'h76;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ADCR_RST_CH4_PHASE_CAL = 8'h00;
    localparam logic [7:0] ADCR_RST_GLOBAL_CFG    = 8'h00;
    localparam logic [7:0] ADCR_RST_DSP_CFG       = 8'h18;
    localparam logic [7:0] ADCR_RST_CHAN_EN       = 8'hCC;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ADCR_PCAL_MSB    = 7;
    localparam int ADCR_PCAL_LSB    = 2;
    localparam int ADCR_TRIM_MSB    = 7;
    localparam int ADCR_TRIM_LSB    = 4;
    localparam int ADCR_QCAL_BIT    = 3;
    localparam int ADCR_INVERT_BIT  = 2;
    localparam int ADCR_DECI_MSB    = 7;
    localparam int ADCR_DECI_LSB    = 6;
    localparam int ADCR_HPF_MSB     = 5;
    localparam int ADCR_HPF_LSB     = 4;
    localparam int ADCR_BQ_MSB      = 3;
    localparam int ADCR_BQ_LSB      = 2;
    localparam int ADCR_SOFT_DIS    = 1;
    localparam int ADCR_GANG_BIT    = 0;
    localparam int ADCR_CHEN_MSB    = 7;
    localparam int ADCR_CHEN_LSB    = 4;

    // Reserved low bits and unmapped reads: read-only constants
    localparam logic [1:0] ADCR_RSVD_CAL_VAL  = 2'h0;
    localparam logic [1:0] ADCR_RSVD_GCFG_VAL = 2'h0;
    localparam logic [3:0] ADCR_RSVD_CHEN_VAL = 4'hC;
    localparam logic [7:0] ADCR_UNMAPPED_VAL  = 8'h00;

    // ------------------------------------------------------------------
    // Data path sizes and volume codes
    // ------------------------------------------------------------------
    localparam int         ADCR_NUM_CH    = 4;
    localparam int         ADCR_SAMPLE_W  = 24;
    localparam int         ADCR_DELAY_MAX = 63;
    localparam int         ADCR_NUM_BQ    = 3;
    localparam logic [7:0] ADCR_VOL_MUTE  = 8'h00;
    localparam logic [7:0] ADCR_VOL_UNITY = 8'hA1;
    localparam logic [7:0] ADCR_VOL_STEP  = 8'h01;

    // ------------------------------------------------------------------
    // Mode enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ADCR_DECI_LINEAR    = 2'h0,
        ADCR_DECI_LOW_LAT   = 2'h1,
        ADCR_DECI_ULTRA_LOW = 2'h2,
        ADCR_DECI_RESERVED  = 2'h3
    } adcr_deci_t;

    typedef enum logic [1:0] {
        ADCR_HPF_IIR      = 2'h0,
        ADCR_HPF_FS_2E5   = 2'h1,
        ADCR_HPF_FS_25E5  = 2'h2,
        ADCR_HPF_FS_25E4  = 2'h3
    } adcr_hpf_t;

endpackage

// File: hdl/adcr_vol_ramp.sv
`timescale 1ns/10ps

module adcr_vol_ramp
    import adcr_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Control
    input  wire logic       step_en,
    input  wire logic       soft_step_enable,
    input  wire logic [7:0] target_volume,
    // Applied gain
    output logic      [7:0] applied_volume,
    output logic            ramp_busy
);

    typedef struct packed {
        logic [7:0] applied;
    } adcr_ramp_state_t;

    adcr_ramp_state_t state;
    adcr_ramp_state_t next_state;

    // Step one code per sample when soft, else jump to target
    always_comb begin
        next_state = state;
        if (!soft_step_enable) begin
            next_state.applied = target_volume;
        end else if (step_en) begin
            if (state.applied < target_volume) begin
                next_state.applied = state.applied + ADCR_VOL_STEP;
            end else if (state.applied > target_volume) begin
                next_state.applied = state.applied - ADCR_VOL_STEP;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state.applied <= ADCR_VOL_UNITY;
        end else begin
            state <= next_state;
        end
    end

    assign applied_volume = state.applied;
    assign ramp_busy      = (state.applied != target_volume);

endmodule

// File: tb/adcr_regs_checker.sv
`timescale 1ns/10ps

module adcr_regs_checker
    import adcr_pkg::*;
(
    // Clock and reset
    input wire logic                        clk_sys,
    input wire logic                        rst,
    // Register port
    input wire logic                        reg_wr_en,
    input wire logic                        reg_rd_en,
    input wire logic [7:0]                  reg_addr,
    input wire logic [7:0]                  reg_wr_data,
    input wire logic [7:0]                  reg_rd_data,
    input wire logic                        reg_rd_valid,
    // Modulator and sample strobes
    input wire logic                        mod_clk_en,
    input wire logic [ADCR_NUM_CH-1:0]      mod_bits_in,
    input wire logic [ADCR_NUM_CH-1:0]      mod_bits_out,
    input wire logic                        sample_in_valid,
    input wire logic                        sample_out_valid,
    // Decoded settings
    input wire logic [ADCR_NUM_CH-1:0][7:0] digital_volume,
    input wire logic [ADCR_NUM_CH-1:0]      channel_mute,
    input wire logic [3:0]                  input_common_mode_trim,
    input wire logic                        quantizer_offset_cal_enable,
    input wire logic [1:0]                  decimation_response_select,
    input wire logic                        decimation_reserved,
    input wire logic [1:0]                  highpass_select,
    input wire logic                        highpass_iir_route,
    input wire logic [1:0]                  biquad_count,
    input wire logic [ADCR_NUM_BQ-1:0]      biquad_stage_enable,
    input wire logic                        soft_step_enable,
    input wire logic                        volume_gang_enable
);
    logic [7:0] wd_q;
    logic [7:0] ad_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Last cycle's write data and address
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wd_q <= 8'h00;
            ad_q <= 8'h00;
        end else begin
            wd_q <= reg_wr_data;
            ad_q <= reg_addr;
        end
    end

    sequence s_dsp_wr;
        reg_wr_en && reg_addr == ADCR_ADDR_DSP_CFG;
    endsequence
    sequence s_gcfg_wr;
        reg_wr_en && reg_addr == ADCR_ADDR_GLOBAL_CFG;
    endsequence

    AST_DSP_FIELDS: assert property (s_dsp_wr |=>
        decimation_response_select == wd_q[7:6] && highpass_select == wd_q[5:4]
        && biquad_count == wd_q[3:2] && soft_step_enable == !wd_q[1]
        && volume_gang_enable == wd_q[0]) else $error("dsp fields wrong");
    AST_GCFG_FIELDS: assert property (s_gcfg_wr |=>
        input_common_mode_trim == wd_q[7:4]
        && quantizer_offset_cal_enable == wd_q[3]) else $error("global fields");
    AST_RD_ANSWER: assert property (
        1'b1 |=> reg_rd_valid == $past(reg_rd_en)) else $error("read valid");
    AST_RSVD_LOW: assert property (reg_rd_valid &&
        (ad_q == ADCR_ADDR_CH4_PHASE_CAL || ad_q == ADCR_ADDR_GLOBAL_CFG)
        |-> reg_rd_data[1:0] == 2'h0) else $error("reserved low bits");
    AST_RSVD_CHEN: assert property (reg_rd_valid &&
        ad_q == ADCR_ADDR_CHAN_EN |-> reg_rd_data[3:0] == 4'hC)
        else $error("reserved enable bits");
    AST_STAGES: assert property ($stable(biquad_count)[*2] |->
        biquad_stage_enable == {biquad_count > 2'h2, biquad_count > 2'h1,
        biquad_count > 2'h0}) else $error("biquad stages");
    AST_DECODES: assert property (
        decimation_reserved == (decimation_response_select == 2'h3)
        && highpass_iir_route == (highpass_select == 2'h0))
        else $error("mode decodes");
    AST_MUTE: assert property (channel_mute ==
        {digital_volume[3] == 8'h00, digital_volume[2] == 8'h00,
        digital_volume[1] == 8'h00, digital_volume[0] == 8'h00})
        else $error("mute decode");
    AST_MOD_PASS: assert property (mod_clk_en |=>
        ((mod_bits_out ^ $past(mod_bits_in)) & 4'h7) == 4'h0)
        else $error("undelayed channels");
    AST_MOD_HOLD: assert property (!mod_clk_en |=>
        $stable(mod_bits_out)) else $error("mod out moved");
    AST_SAMPLE_VALID: assert property (
        1'b1 |=> sample_out_valid == $past(sample_in_valid))
        else $error("sample valid");
endmodule

bind adcr_regs adcr_regs_checker u_chk (.clk_sys, .rst, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_valid,
    .mod_clk_en, .mod_bits_in, .mod_bits_out, .sample_in_valid,
    .sample_out_valid, .digital_volume, .channel_mute,
    .input_common_mode_trim, .quantizer_offset_cal_enable,
    .decimation_response_select, .decimation_reserved, .highpass_select,
    .highpass_iir_route, .biquad_count, .biquad_stage_enable,
    .soft_step_enable, .volume_gang_enable);

// File: tb/adcr_regs_tb.sv
`timescale 1ns/10ps

module adcr_regs_tb
    import adcr_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic            clk_sys, rst, reg_wr_en, reg_rd_en, mod_clk_en;
    logic            sample_in_valid, reg_rd_valid, sample_out_valid;
    logic            quantizer_offset_cal_enable, decimation_reserved;
    logic            highpass_iir_route, soft_step_enable, volume_gang_enable;
    logic [7:0]      reg_addr, reg_wr_data, reg_rd_data, d;
    logic [3:0]      mod_bits_in, mod_bits_out, channel_mute, volume_ramping;
    logic [3:0]      input_common_mode_trim, input_channel_enable, t;
    logic [1:0]      decimation_response_select, highpass_select, biquad_count;
    logic [2:0]      biquad_stage_enable;
    logic [3:0][23:0] sample_in, sample_out;
    logic [3:0][7:0] per_channel_volume, digital_volume;
    logic [23:0]     x, e;
    logic            hist [0:79];
    int              error_cnt, n_tests, i, k, n;

    adcr_regs dut (.clk_sys, .rst, .reg_wr_en, .reg_rd_en, .reg_addr,
        .reg_wr_data, .reg_rd_data, .reg_rd_valid, .mod_clk_en, .mod_bits_in,
        .mod_bits_out, .sample_in_valid, .sample_in, .sample_out_valid,
        .sample_out, .per_channel_volume, .digital_volume, .channel_mute,
        .volume_ramping, .input_common_mode_trim, .quantizer_offset_cal_enable,
        .decimation_response_select, .decimation_reserved, .highpass_select,
        .highpass_iir_route, .biquad_count, .biquad_stage_enable,
        .soft_step_enable, .volume_gang_enable, .input_channel_enable);

    // Clock, 4 ns period
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex, got);
        n_tests++;
        if (got !== ex) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, dat);
        @(negedge clk_sys);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = dat;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
    endtask

    // Read strobe; valid is registered on the taking edge and checked half a cycle later
    task automatic rd(input logic [7:0] a, ex);
        @(negedge clk_sys);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        chk("rd_valid", 1'b1, reg_rd_valid);
        chk("rd_data", ex, reg_rd_data);
    endtask

    task automatic strobe;
        @(negedge clk_sys);
        sample_in_valid = 1'b1;
        @(negedge clk_sys);
        sample_in_valid = 1'b0;
    endtask

    // Hang guard
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {reg_wr_en, reg_rd_en, mod_clk_en, sample_in_valid} = 4'h0;
        {reg_addr, reg_wr_data, mod_bits_in} = 20'h00000;
        sample_in = '0;
        per_channel_volume = '0;
        error_cnt = 0;
        n_tests = 0;
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        rd(8'h61, 8'h00);
        rd(8'h62, 8'h00);
        rd(8'h72, 8'h18);
        rd(8'h76, 8'hCC);
        rd(8'h63, 8'h00);
        chk("chan_en", 4'h3, input_channel_enable);
        wr(8'h61, 8'hFC);
        rd(8'h61, 8'hFC);
        wr(8'h76, 8'h5C);
        rd(8'h76, 8'h5C);
        chk("chan_en", 4'hA, input_channel_enable);
        // Every one-hot trim code, then none
        for (i = 0; i < 5; i++) begin
            t = (i == 4) ? 4'h0 : 4'h1 << i;
            wr(8'h62, {t, i[0], 3'h4});
            chk("trim", t, input_common_mode_trim);
            chk("qcal", i[0], quantizer_offset_cal_enable);
        end
        // Every code of each DSP field
        for (i = 0; i < 4; i++) begin
            d = {i[1:0], i[1:0], i[1:0], i[0], i[1]};
            wr(8'h72, d);
            repeat (2) @(negedge clk_sys);
            chk("deci", i[1:0], decimation_response_select);
            chk("hpf", i[1:0], highpass_select);
            chk("bq", i[1:0], biquad_count);
            chk("stages", {i > 2, i > 1, i > 0}, biquad_stage_enable);
            chk("soft", !i[0], soft_step_enable);
            chk("gang", i[1], volume_gang_enable);
            rd(8'h72, d);
        end
        // Sample path, plain then inverted, with the negative extreme
        wr(8'h76, 8'hFC);
        sample_in = {24'h000005, 24'h800000, 24'h7FFFFF, 24'h123456};
        for (i = 0; i < 2; i++) begin
            wr(8'h62, i[0] ? 8'h04 : 8'h00);
            strobe();
            for (k = 0; k < 4; k++) begin
                x = sample_in[k];
                e = !i[0] ? x : (x == 24'h800000 ? 24'h7FFFFF : -x);
                chk("sample", e, sample_out[k]);
            end
        end
        wr(8'h76, 8'hDC);
        strobe();
        chk("disabled ch3", 24'h0, sample_out[2]);
        // Volume: own codes without soft-stepping, then ganged
        per_channel_volume = {8'h40, 8'h00, 8'h20, 8'h10};
        wr(8'h76, 8'hFC);
        wr(8'h72, 8'h1A);
        repeat (3) @(negedge clk_sys);
        chk("vol own", per_channel_volume, digital_volume);
        chk("mute", 4'h4, channel_mute);
        wr(8'h76, 8'h7C);
        wr(8'h72, 8'h1B);
        repeat (3) @(negedge clk_sys);
        chk("vol gang", 32'h10101000, digital_volume);
        // Soft-stepping moves one code per strobe
        wr(8'h76, 8'hFC);
        wr(8'h72, 8'h18);
        repeat (4) strobe();
        repeat (2) @(negedge clk_sys);
        chk("ramp up", 8'h14, digital_volume[1]);
        chk("ramp down", 8'h0C, digital_volume[2]);
        chk("ramping", 1'b1, volume_ramping[1]);
        wr(8'h72, 8'h1A);
        repeat (3) @(negedge clk_sys);
        chk("jump", 8'h20, digital_volume[1]);
        chk("ramping", 1'b0, volume_ramping[1]);
        // Channel 4 delay of 0, 1 and 63 enables
        for (i = 0; i < 3; i++) begin
            n = (i == 0) ? 0 : (i == 1) ? 1 : 63;
            wr(8'h61, {n[5:0], 2'h0});
            for (k = 0; k < 72; k++) begin
                hist[k] = k[0] ^ k[3] ^ k[5];
                @(negedge clk_sys);
                mod_clk_en = 1'b1;
                mod_bits_in = {hist[k], k[2:0]};
                @(negedge clk_sys);
                mod_clk_en = 1'b0;
                if (k >= n)
                    chk("ch4 delayed", hist[k - n], mod_bits_out[3]);
            end
        end
        finish_test();
    end
endmodule
